// ### pkg/irq_wake_pkg.sv
// How it works
// - Flag register two holds only the timer gate event flag at bit 5.
// - An implemented flag reads one after its request occurred or a write of one, else zero.
// - Flag register three bit 2 is the second serial port collision flag.
// - Flag register three bit 1 is the second serial port event flag.
// - Without the second serial port both its flags read zero.
// - Bits 15 to 3 of flag three and priority five, and bit 0 of flag three, read zero.
// - Priority bits 2..0 set external interrupt one level; zero disables it.
// - Enable and sink bits both set connect the discharge sink.
// - With the wake enable bit set, wake pin below input low threshold in sleep resumes execution.
// - A wake by the low power source sets flag five bit 0.
package irq_wake_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;
   localparam int PRIO_W = 3;
   localparam int EVT_W  = 5;

   // Word indices on the register bus (byte address is index times four)
   localparam logic [5:0] IDX_FLAGS_TWO   = 6'h00;
   localparam logic [5:0] IDX_FLAGS_THREE = 6'h01;
   localparam logic [5:0] IDX_FLAGS_FIVE  = 6'h02;
   localparam logic [5:0] IDX_PRIO_FIVE   = 6'h03;
   localparam logic [5:0] IDX_WAKE_CTRL   = 6'h04;
   localparam logic [5:0] IDX_EXT_FLAGS   = 6'h05;
   localparam logic [5:0] IDX_EVT_STATUS  = 6'h06;
   localparam logic [5:0] IDX_EVT_MASK    = 6'h07;
   localparam logic [5:0] IDX_UNIT_STATE  = 6'h08;

   // Field positions
   localparam int TIMER_GATE_BIT  = 5;
   localparam int COLLISION_BIT   = 2;
   localparam int SERIAL_EVT_BIT  = 1;
   localparam int WAKE_FLAG_BIT   = 0;
   localparam int EXT_ONE_BIT     = 0;
   localparam int WAKE_ENABLE_BIT = 0;
   localparam int SINK_ENABLE_BIT = 1;
   localparam int ST_ASLEEP_BIT   = 0;
   localparam int ST_SINK_BIT     = 1;
   localparam int ST_PIN_LOW_BIT  = 2;

   // Event order in status and mask registers
   localparam int EVT_TIMER_GATE = 0;
   localparam int EVT_COLLISION  = 1;
   localparam int EVT_SERIAL     = 2;
   localparam int EVT_WAKE       = 3;
   localparam int EVT_EXT_ONE    = 4;

   // Values after reset
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
   localparam logic [EVT_W-1:0]  EVT_RESET  = 5'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### pkg/wake_link_if.sv
`timescale 1ns/1ps
interface wake_link_if;
   logic wake_enable;
   logic sink_enable;
   logic sleep_enter;
   logic pin_low;
   logic wake_pulse;
   logic asleep;
   logic sink_on;

   modport ctrl (
      output wake_enable,
      output sink_enable,
      output sleep_enter,
      output pin_low,
      input  wake_pulse,
      input  asleep,
      input  sink_on
   );

   modport unit (
      input  wake_enable,
      input  sink_enable,
      input  sleep_enter,
      input  pin_low,
      output wake_pulse,
      output asleep,
      output sink_on
   );
endinterface

// ### rtl/wake_unit.sv
`timescale 1ns/1ps
module wake_unit (
   input  wire logic    clk_in,
   input  wire logic    rstn_in,
   wake_link_if.unit    link
);
   typedef enum logic {AWAKE, ASLEEP} sleep_state_type;

   sleep_state_type state_q;
   logic            wake_q;
   logic            sink_q;

   assign link.asleep     = (state_q == ASLEEP);
   assign link.wake_pulse = wake_q;
   assign link.sink_on    = sink_q;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sink_q <= 1'b0;
      end else begin
         sink_q <= link.wake_enable & link.sink_enable;
      end
   end

   // Pin level is only judged while asleep; awake, software owns the pin
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= AWAKE;
         wake_q  <= 1'b0;
      end else begin
         wake_q <= 1'b0;
         case (state_q)
            AWAKE: begin
               if (link.sleep_enter) begin
                  state_q <= ASLEEP;
               end
            end
            ASLEEP: begin
               if (link.wake_enable && link.pin_low) begin
                  state_q <= AWAKE;
                  wake_q  <= 1'b1;
               end
            end
            default: state_q <= AWAKE;
         endcase
      end
   end
endmodule

// ### rtl/irq_forward.sv
`timescale 1ns/1ps
module irq_forward (
   input  wire logic                        clk_in,
   input  wire logic                        rstn_in,
   input  wire logic                        pending_in,
   input  wire logic [irq_wake_pkg::PRIO_W-1:0] prio_in,
   output logic                             req_out,
   output logic [irq_wake_pkg::PRIO_W-1:0]  level_out
);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         req_out   <= 1'b0;
         level_out <= '0;
      end else begin
         req_out   <= pending_in && (prio_in != '0);
         level_out <= prio_in;
      end
   end
endmodule

// ### rtl/irq_flag_wake_top.sv
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module irq_flag_wake_top #(
   parameter logic HAS_SERIAL2 = 1'b1
) (
   input  wire logic                              clk_in,
   input  wire logic                              rstn_in,
   input  wire logic [irq_wake_pkg::ADDR_W-1:0]   s_axi_awaddr_in,
   input  wire logic [2:0]                        s_axi_awprot_in,
   input  wire logic                              s_axi_awvalid_in,
   output logic                                   s_axi_awready_out,
   input  wire logic [irq_wake_pkg::DATA_W-1:0]   s_axi_wdata_in,
   input  wire logic [3:0]                        s_axi_wstrb_in,
   input  wire logic                              s_axi_wvalid_in,
   output logic                                   s_axi_wready_out,
   output logic [1:0]                             s_axi_bresp_out,
   output logic                                   s_axi_bvalid_out,
   input  wire logic                              s_axi_bready_in,
   input  wire logic [irq_wake_pkg::ADDR_W-1:0]   s_axi_araddr_in,
   input  wire logic [2:0]                        s_axi_arprot_in,
   input  wire logic                              s_axi_arvalid_in,
   output logic                                   s_axi_arready_out,
   output logic [irq_wake_pkg::DATA_W-1:0]        s_axi_rdata_out,
   output logic [1:0]                             s_axi_rresp_out,
   output logic                                   s_axi_rvalid_out,
   input  wire logic                              s_axi_rready_in,
   input  wire logic                              timer_gate_event_in,
   input  wire logic                              serial2_collision_in,
   input  wire logic                              serial2_event_in,
   input  wire logic                              ext_irq_one_in,
   input  wire logic                              sleep_enter_in,
   input  wire logic                              wake_pin_low_in,
   output logic                                   sink_on_out,
   output logic                                   asleep_out,
   output logic                                   wake_resume_out,
   output logic                                   ext_one_req_out,
   output logic [irq_wake_pkg::PRIO_W-1:0]        ext_one_level_out,
   output logic                                   irq_out
);

   ////////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte-lane merge of a 16-bit register; lanes 2 and 3 have no storage
   function automatic logic [irq_wake_pkg::REG_W-1:0] merge16(
      input logic [irq_wake_pkg::REG_W-1:0]  old_val,
      input logic [irq_wake_pkg::DATA_W-1:0] data,
      input logic [3:0]                      strb
   );
      logic [irq_wake_pkg::REG_W-1:0] res;
      res       = old_val;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      return idx <= irq_wake_pkg::IDX_UNIT_STATE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic                                aw_held_q;
   logic [5:0]                          aw_idx_q;
   logic                                w_held_q;
   logic [irq_wake_pkg::DATA_W-1:0]     w_data_q;
   logic [3:0]                          w_strb_q;
   logic                                awready_q;
   logic                                wready_q;
   logic                                bvalid_q;
   logic [1:0]                          bresp_q;
   logic                                arready_q;
   logic                                rvalid_q;
   logic [1:0]                          rresp_q;
   logic [irq_wake_pkg::DATA_W-1:0]     rdata_q;
   logic                                do_write;
   logic [irq_wake_pkg::REG_W-1:0]      wmerge;

   logic                                timer_gate_event_flag_q;
   logic                                serial2_collision_flag_q;
   logic                                serial2_event_flag_q;
   logic                                wake_source_flag_q;
   logic                                ext_one_flag_q;
   logic [irq_wake_pkg::PRIO_W-1:0]     ext_irq_one_priority_q;
   logic                                wake_source_enable_q;
   logic                                discharge_sink_enable_q;
   logic [irq_wake_pkg::EVT_W-1:0]      evt_status_q;
   logic [irq_wake_pkg::EVT_W-1:0]      evt_mask_q;
   logic [irq_wake_pkg::EVT_W-1:0]      evt_now;
   logic                                collision_evt;
   logic                                serial_evt;
   logic [irq_wake_pkg::REG_W-1:0]      rd_word;
   logic [5:0]                          rd_idx;

   wake_link_if link ();

   ////////////////////////////////////////////////////////////////////////////////////
   // Register bus: write path

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign wmerge   = merge16('0, w_data_q, w_strb_q);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         aw_held_q <= 1'b0;
         aw_idx_q  <= '0;
         awready_q <= 1'b1;
      end else if (s_axi_awvalid_in && awready_q) begin
         aw_held_q <= 1'b1;
         aw_idx_q  <= s_axi_awaddr_in[7:2];
         awready_q <= 1'b0;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready_in) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         wready_q <= 1'b1;
      end else if (s_axi_wvalid_in && wready_q) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata_in;
         w_strb_q <= s_axi_wstrb_in;
         wready_q <= 1'b0;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready_in) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bvalid_q <= 1'b0;
         bresp_q  <= irq_wake_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= is_mapped(aw_idx_q) ? irq_wake_pkg::RESP_OKAY
                                         : irq_wake_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Flags: the event wins over a clearing write in the same cycle

   function automatic logic flag_next(
      input logic cur,
      input logic evt,
      input logic wr,
      input logic wbit
   );
      return evt | (wr ? wbit : cur);
   endfunction

   // A missing serial port never raises its events
   assign collision_evt = HAS_SERIAL2 & serial2_collision_in;
   assign serial_evt    = HAS_SERIAL2 & serial2_event_in;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         timer_gate_event_flag_q <= 1'b0;
      end else begin
         timer_gate_event_flag_q <= flag_next(timer_gate_event_flag_q,
            timer_gate_event_in,
            do_write && (aw_idx_q == irq_wake_pkg::IDX_FLAGS_TWO) && w_strb_q[0],
            wmerge[irq_wake_pkg::TIMER_GATE_BIT]);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         serial2_collision_flag_q <= 1'b0;
         serial2_event_flag_q     <= 1'b0;
      end else if (HAS_SERIAL2) begin
         serial2_collision_flag_q <= flag_next(serial2_collision_flag_q,
            collision_evt,
            do_write && (aw_idx_q == irq_wake_pkg::IDX_FLAGS_THREE) && w_strb_q[0],
            wmerge[irq_wake_pkg::COLLISION_BIT]);
         serial2_event_flag_q <= flag_next(serial2_event_flag_q,
            serial_evt,
            do_write && (aw_idx_q == irq_wake_pkg::IDX_FLAGS_THREE) && w_strb_q[0],
            wmerge[irq_wake_pkg::SERIAL_EVT_BIT]);
      end else begin
         serial2_collision_flag_q <= 1'b0;
         serial2_event_flag_q     <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wake_source_flag_q <= 1'b0;
      end else begin
         wake_source_flag_q <= flag_next(wake_source_flag_q,
            link.wake_pulse,
            do_write && (aw_idx_q == irq_wake_pkg::IDX_FLAGS_FIVE) && w_strb_q[0],
            wmerge[irq_wake_pkg::WAKE_FLAG_BIT]);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ext_one_flag_q <= 1'b0;
      end else begin
         ext_one_flag_q <= flag_next(ext_one_flag_q,
            ext_irq_one_in,
            do_write && (aw_idx_q == irq_wake_pkg::IDX_EXT_FLAGS) && w_strb_q[0],
            wmerge[irq_wake_pkg::EXT_ONE_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Priority and wake control

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ext_irq_one_priority_q <= irq_wake_pkg::PRIO_RESET;
      end else if (do_write && (aw_idx_q == irq_wake_pkg::IDX_PRIO_FIVE) && w_strb_q[0]) begin
         ext_irq_one_priority_q <= wmerge[irq_wake_pkg::PRIO_W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wake_source_enable_q    <= 1'b0;
         discharge_sink_enable_q <= 1'b0;
      end else if (do_write && (aw_idx_q == irq_wake_pkg::IDX_WAKE_CTRL) && w_strb_q[0]) begin
         wake_source_enable_q    <= wmerge[irq_wake_pkg::WAKE_ENABLE_BIT];
         discharge_sink_enable_q <= wmerge[irq_wake_pkg::SINK_ENABLE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Interrupt status (write one to clear), mask and output

   always_comb begin
      evt_now                              = '0;
      evt_now[irq_wake_pkg::EVT_TIMER_GATE] = timer_gate_event_in;
      evt_now[irq_wake_pkg::EVT_COLLISION]  = collision_evt;
      evt_now[irq_wake_pkg::EVT_SERIAL]     = serial_evt;
      evt_now[irq_wake_pkg::EVT_WAKE]       = link.wake_pulse;
      evt_now[irq_wake_pkg::EVT_EXT_ONE]    = ext_irq_one_in;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         evt_status_q <= irq_wake_pkg::EVT_RESET;
      end else if (do_write && (aw_idx_q == irq_wake_pkg::IDX_EVT_STATUS) && w_strb_q[0]) begin
         evt_status_q <= (evt_status_q & ~wmerge[irq_wake_pkg::EVT_W-1:0]) | evt_now;
      end else begin
         evt_status_q <= evt_status_q | evt_now;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         evt_mask_q <= irq_wake_pkg::EVT_RESET;
      end else if (do_write && (aw_idx_q == irq_wake_pkg::IDX_EVT_MASK) && w_strb_q[0]) begin
         evt_mask_q <= wmerge[irq_wake_pkg::EVT_W-1:0];
      end
   end

   // Registered, so the line follows the status by one cycle
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(evt_status_q & evt_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Register bus: read path

   assign rd_idx = s_axi_araddr_in[7:2];

   always_comb begin
      rd_word = '0;
      case (rd_idx)
         irq_wake_pkg::IDX_FLAGS_TWO: begin
            rd_word[irq_wake_pkg::TIMER_GATE_BIT] = timer_gate_event_flag_q;
         end
         irq_wake_pkg::IDX_FLAGS_THREE: begin
            rd_word[irq_wake_pkg::COLLISION_BIT]  = serial2_collision_flag_q;
            rd_word[irq_wake_pkg::SERIAL_EVT_BIT] = serial2_event_flag_q;
         end
         irq_wake_pkg::IDX_FLAGS_FIVE: begin
            rd_word[irq_wake_pkg::WAKE_FLAG_BIT] = wake_source_flag_q;
         end
         irq_wake_pkg::IDX_PRIO_FIVE: begin
            rd_word[irq_wake_pkg::PRIO_W-1:0] = ext_irq_one_priority_q;
         end
         irq_wake_pkg::IDX_WAKE_CTRL: begin
            rd_word[irq_wake_pkg::WAKE_ENABLE_BIT] = wake_source_enable_q;
            rd_word[irq_wake_pkg::SINK_ENABLE_BIT] = discharge_sink_enable_q;
         end
         irq_wake_pkg::IDX_EXT_FLAGS: begin
            rd_word[irq_wake_pkg::EXT_ONE_BIT] = ext_one_flag_q;
         end
         irq_wake_pkg::IDX_EVT_STATUS: begin
            rd_word[irq_wake_pkg::EVT_W-1:0] = evt_status_q;
         end
         irq_wake_pkg::IDX_EVT_MASK: begin
            rd_word[irq_wake_pkg::EVT_W-1:0] = evt_mask_q;
         end
         irq_wake_pkg::IDX_UNIT_STATE: begin
            rd_word[irq_wake_pkg::ST_ASLEEP_BIT]  = link.asleep;
            rd_word[irq_wake_pkg::ST_SINK_BIT]    = link.sink_on;
            rd_word[irq_wake_pkg::ST_PIN_LOW_BIT] = wake_pin_low_in;
         end
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= irq_wake_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_in && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= {16'h0000, rd_word};
         rresp_q   <= is_mapped(rd_idx) ? irq_wake_pkg::RESP_OKAY
                                        : irq_wake_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_in) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out  = wready_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;

   ////////////////////////////////////////////////////////////////////////////////////
   // Wake unit and request forwarding

   // Pin charging is left to software through the port logic
   assign link.wake_enable = wake_source_enable_q;
   assign link.sink_enable = discharge_sink_enable_q;
   assign link.sleep_enter = sleep_enter_in;
   assign link.pin_low     = wake_pin_low_in;

   wake_unit u_wake (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .link    (link.unit)
   );

   assign sink_on_out     = link.sink_on;
   assign asleep_out      = link.asleep;
   assign wake_resume_out = link.wake_pulse;

   irq_forward u_forward (
      .clk_in     (clk_in),
      .rstn_in    (rstn_in),
      .pending_in (ext_one_flag_q),
      .prio_in    (ext_irq_one_priority_q),
      .req_out    (ext_one_req_out),
      .level_out  (ext_one_level_out)
   );

endmodule

// ### verif/irq_flag_wake_checker.sv
`timescale 1ns/1ps
module irq_flag_wake_checker (
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic        sleep_enter_in,
   input wire logic        wake_pin_low_in,
   input wire logic        asleep_out,
   input wire logic        wake_resume_out,
   input wire logic        ext_one_req_out,
   input wire logic [2:0]  ext_one_level_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////////
   sleep_entry_a: assert property (sleep_enter_in && !asleep_out |=> asleep_out)
      else $error("sleep entry not taken");
   wake_exit_a: assert property ($fell(asleep_out) |-> wake_resume_out)
      else $error("sleep left without resume pulse");
   wake_cause_a: assert property (wake_resume_out |-> $past(asleep_out) && $past(wake_pin_low_in))
      else $error("resume without low pin in sleep");
   resume_pulse_a: assert property (wake_resume_out |=> !wake_resume_out)
      else $error("resume pulse too long");
   forward_prio_a: assert property (ext_one_req_out |-> ext_one_level_out != 3'h0)
      else $error("request forwarded at priority zero");
   resp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("write response dropped");
   read_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data not held");
   upper_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
      else $error("unimplemented bits read nonzero");
endmodule
bind irq_flag_wake_top irq_flag_wake_checker chk_u (.clk_in(clk_in), .rstn_in(rstn_in),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
   .s_axi_rdata_out(s_axi_rdata_out), .sleep_enter_in(sleep_enter_in),
   .wake_pin_low_in(wake_pin_low_in), .asleep_out(asleep_out),
   .wake_resume_out(wake_resume_out), .ext_one_req_out(ext_one_req_out),
   .ext_one_level_out(ext_one_level_out));

// ### verif/core_model.sv
`timescale 1ns/1ps
module core_model (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       start_in,
   input  wire logic       sink_on_in,
   input  wire logic       wake_resume_in,
   input  wire logic [7:0] hold_in,
   output logic            sleep_enter_out,
   output logic            pin_low_out
);
   logic [7:0] charge_q;
   logic       armed_q;
   // Pin stays above threshold unless a charged capacitor has fully drained
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         charge_q        <= 8'h00;
         armed_q         <= 1'h0;
         sleep_enter_out <= 1'h0;
      end else begin
         sleep_enter_out <= start_in;
         if (start_in) begin
            charge_q <= hold_in;
            armed_q  <= 1'h1;
         end else if (wake_resume_in) begin
            armed_q <= 1'h0;
         end else if (sink_on_in && charge_q != 8'h00) begin
            charge_q <= charge_q - 8'h01;
         end
      end
   end
   assign pin_low_out = armed_q && charge_q == 8'h00;
endmodule

// ### verif/test_irq_flag_priority_ulp_wake.sv
`timescale 1ns/1ps
module test_irq_flag_priority_ulp_wake;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} row_type;
   logic clk = 1'h0, rstn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0;
   logic rready = 1'h0, tge = 1'h0, col = 1'h0, sev = 1'h0, ext = 1'h0, start = 1'h0;
   logic awrdy, wrdy, bvalid, arrdy, rvalid, sink, asleep, resume, req, irq, slp, pinl;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, hold = 8'h05;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [2:0]  lvl;
   int fail_count = 0, cmp_count = 0, n;
   row_type rows [8] = '{'{8'h00, 32'hFFFF, 32'h20, 2'h0}, '{8'h00, 32'h0, 32'h0, 2'h0},
      '{8'h04, 32'hFFFF, 32'h6, 2'h0}, '{8'h04, 32'h0, 32'h0, 2'h0},
      '{8'h0C, 32'hFFFFFFFF, 32'h7, 2'h0}, '{8'h0C, 32'h1, 32'h1, 2'h0},
      '{8'h14, 32'h1, 32'h1, 2'h0}, '{8'h40, 32'hFFFF, 32'h0, 2'h2}};
   always #5 clk = ~clk;
   irq_flag_wake_top uut (.clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
      .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arprot_in(3'h0),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .timer_gate_event_in(tge), .serial2_collision_in(col), .serial2_event_in(sev),
      .ext_irq_one_in(ext), .sleep_enter_in(slp), .wake_pin_low_in(pinl), .sink_on_out(sink),
      .asleep_out(asleep), .wake_resume_out(resume), .ext_one_req_out(req),
      .ext_one_level_out(lvl), .irq_out(irq));
   core_model cm (.clk_in(clk), .rstn_in(rstn), .start_in(start), .sink_on_in(sink),
      .wake_resume_in(resume), .hold_in(hold), .sleep_enter_out(slp), .pin_low_out(pinl));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Valid and payload are held until the edge that samples ready
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      awaddr <= a;
      wdata <= dat;
      awv <= 1'h1;
      wv <= 1'h1;
      do begin
         @(posedge clk);
         if (awrdy) awv <= 1'h0;
         if (wrdy) wv <= 1'h0;
         if (!bready) bready <= bvalid;
      end while (bvalid !== 1'h1 || !bready);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arv <= 1'h1;
      do begin
         @(posedge clk);
         if (arrdy) arv <= 1'h0;
         if (!rready) rready <= rvalid;
      end while (rvalid !== 1'h1 || !rready);
      {r, d} = {rresp, rdata};
      rready <= 1'h0;
   endtask
   task automatic pulse(input logic [7:0] a, input logic [31:0] e);
      {tge, col, sev} <= 3'h7;
      @(posedge clk);
      {tge, col, sev} <= 3'h0;
      repeat (3) @(posedge clk);
      rd(a);
      chk(d, e);
   endtask
   task automatic results;
      if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #300us;
      fail_count++;
      results;
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         chk({30'h0, r}, {30'h0, rows[i].r});
         rd(rows[i].a);
         chk(d, rows[i].e);
         chk({30'h0, r}, {30'h0, rows[i].r});
      end
      wr(8'h1C, 32'h0);
      pulse(8'h00, 32'h20);
      chk(irq, 1'h0);
      pulse(8'h04, 32'h6);
      wr(8'h1C, 32'h1F);
      repeat (3) @(posedge clk);
      chk(irq, 1'h1);
      wr(8'h18, 32'h1F);
      wr(8'h00, 32'h0);
      rd(8'h00);
      chk(d, 32'h0);
      for (int p = 0; p < 8; p++) begin
         wr(8'h0C, p);
         ext <= 1'h1;
         @(posedge clk);
         ext <= 1'h0;
         repeat (3) @(posedge clk);
         chk({req, lvl}, {p != 0, p[2:0]});
         wr(8'h14, 32'h0);
      end
      wr(8'h18, 32'h1F);
      wr(8'h10, 32'h3);
      repeat (2) @(posedge clk);
      chk(sink, 1'h1);
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      n = 0;
      while (resume !== 1'h1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      chk({asleep, irq}, 2'h1);
      rd(8'h08);
      chk(d, 32'h1);
      wr(8'h10, 32'h1);
      repeat (2) @(posedge clk);
      chk(sink, 1'h0);
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      rd(8'h0C);
      chk(d, 32'h4);
      rd(8'h08);
      chk(d, 32'h0);
      results;
   end
endmodule
